// File: tb_top.sv
/*
  self-checking bench of the monitor: bus tasks, lfsr stimulus, checks.
  assumes the package, design and alarm model are compiled first.
*/
`timescale 1ns/1ns
module tb_top
  import wtm_pkg::*;
;
  localparam int STEP = 4; // short step keeps the run brief
  localparam int HOLD = 20; // short fail hold
  logic clk_in = 1'b0;
  logic reset_n_in = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [7:0] cpu_t = 8'h06; // in limits after reset
  logic [7:0] hsg_t = 8'h06;
  logic [31:0] rdata;
  logic relay;
  logic [1:0] run_led;
  logic [1:0] temp_led;
  logic sys_rst;
  logic irq;
  logic [31:0] low_len;
  logic [31:0] lfsr_q = 32'h46da;
  int failures = 0;
  int total_checks = 0;

  always #5 clk_in = ~clk_in;

  wtm_monitor #(.STEP_CYC(STEP), .HOLD_CYC(HOLD)) u_wtm_monitor (.clk_in(clk_in), .reset_n_in(reset_n_in),
    .addr_in(addr), .wdata_in(wdata), .wr_in(wr), .rd_in(rd), .cpu_temp_in(cpu_t), .hsg_temp_in(hsg_t),
    .rdata_out(rdata), .relay_work_out(relay), .run_led_out(run_led), .temp_led_out(temp_led),
    .sys_reset_out(sys_rst), .irq_out(irq));
  wtm_alarm_model u_wtm_alarm_model (.clk_in(clk_in), .reset_n_in(reset_n_in), .relay_work_in(relay),
    .low_len_out(low_len));

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [31:0] lfsr_next(input logic [31:0] s);
    lfsr_next = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  // out of band on either side counts, the limits themselves do not
  function automatic logic temp_bad(input logic [7:0] t, input logic [15:0] lim);
    temp_bad = (t > lim[15:8]) || (t < lim[7:0]);
  endfunction
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, got);
    end
  endtask
  // each task ends 1 ns after an edge so outputs are settled
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_in);
    #1;
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
    @(posedge clk_in);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk_in);
    wr <= 1'b0;
    #1;
  endtask
  // read data stands only in the cycle after the strobe
  task automatic rd_reg(input logic [3:0] a, output logic [31:0] d);
    @(posedge clk_in);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk_in);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask
  task automatic report_and_stop();
    $display("checks %0d failures %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ----------------------------------------
  // timeout guard
  // ----------------------------------------
  initial
  begin
    #500000;
    failures++;
    report_and_stop();
  end

  // ----------------------------------------
  // main sequence
  // ----------------------------------------
  initial
  begin
    logic [31:0] d;
    logic [15:0] clim;
    logic [15:0] hlim;
    logic [7:0] ct;
    logic [7:0] ht;
    logic bad;
    logic seen;
    int n;
    // quiet while reset is held
    cyc(3);
    chk("relay", 32'h0, relay);
    chk("run_led", WTM_LED_OFF, run_led);
    chk("sys_rst", 32'h0, sys_rst);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    cyc(6);
    chk("temp_led", WTM_LED_GREEN, temp_led);
    rd_reg(WTM_REG_TIME, d);
    chk("time_rst", WTM_TIME_RST, d);
    rd_reg(WTM_REG_CPU_LIM, d);
    chk("lim_rst", {WTM_LIM_HI_RST, WTM_LIM_LO_RST}, d[15:0]);
    rd_reg(4'hf, d);
    chk("unmapped", 32'h0, d);
    $display("test reset done");
    // arm, then acknowledge
    wr_reg(WTM_REG_IRQ_EN, 32'h3);
    wr_reg(WTM_REG_TIME, 32'h3);
    wr_reg(WTM_REG_CTRL, 32'h7);
    chk("run_led", WTM_LED_GREEN, run_led);
    chk("relay", 32'h0, relay);
    wr_reg(WTM_REG_CTRL, 32'h17);
    chk("relay", 32'h1, relay);
    // random retrigger spacing always inside the shortest interval
    repeat (8)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      cyc(1 + lfsr_q[1:0]);
      wr_reg(WTM_REG_KICK, lfsr_q);
    end
    chk("run_led", WTM_LED_GREEN, run_led);
    // rewriting the time retriggers just as a kick does
    repeat (6)
    begin
      cyc(4);
      wr_reg(WTM_REG_TIME, 32'h3);
    end
    chk("run_led", WTM_LED_GREEN, run_led);
    $display("test retrigger done");
    // let it expire and time the reaction
    n = 0;
    while (run_led !== WTM_LED_RED && n < 40)
    begin
      cyc(1);
      n++;
    end
    if (n == 40)
    begin
      failures++;
      report_and_stop();
    end
    chk("expiry_cycles", 3 * STEP, n);
    chk("relay", 32'h0, relay);
    cyc(1);
    chk("sys_rst", 32'h1, sys_rst);
    chk("irq", 32'h1, irq);
    // software cannot lift the fail state, nor can a rearm inside the hold
    wr_reg(WTM_REG_TIME, 32'hff);
    wr_reg(WTM_REG_CTRL, 32'h10);
    chk("relay", 32'h0, relay);
    wr_reg(WTM_REG_CTRL, 32'h1);
    wr_reg(WTM_REG_CTRL, 32'h11);
    chk("relay", 32'h0, relay);
    n = 0;
    while (relay !== 1'b1 && n < 40)
    begin
      wr_reg(WTM_REG_CTRL, 32'h17);
      n++;
    end
    if (n == 40)
    begin
      failures++;
      report_and_stop();
    end
    cyc(1);
    chk("hold_ok", 32'h1, {31'h0, low_len >= HOLD});
    rd_reg(WTM_REG_IRQ_STAT, d);
    chk("stat_exp", 32'h1, d[WTM_EV_EXPIRE]);
    wr_reg(WTM_REG_IRQ_CLR, 32'h1);
    cyc(1);
    chk("irq", 32'h0, irq);
    $display("test expiry done");
    // temperature: separate random limits, boundary temps first
    wr_reg(WTM_REG_CTRL, 32'h8);
    lfsr_q = lfsr_next(lfsr_q);
    clim = {8'h40 + lfsr_q[7:4], 8'h10 + lfsr_q[3:0]};
    hlim = {8'h30 + lfsr_q[15:12], 8'h20 + lfsr_q[11:8]};
    wr_reg(WTM_REG_CPU_LIM, {16'h0, clim});
    wr_reg(WTM_REG_HSG_LIM, {16'h0, hlim});
    seen = 1'b0;
    for (int i = 0; i < 14; i++)
    begin
      lfsr_q = lfsr_next(lfsr_q);
      ct = (i == 0) ? clim[15:8] : (i == 1) ? clim[15:8] + 8'h01 : {1'b0, lfsr_q[6:0]};
      ht = (i < 2) ? hlim[7:0] : (i == 2) ? hlim[7:0] - 8'h01 : {1'b0, lfsr_q[14:8]};
      @(posedge clk_in);
      cpu_t <= ct;
      hsg_t <= ht;
      cyc(8);
      bad = temp_bad(ct, clim) || temp_bad(ht, hlim);
      seen = seen | bad;
      chk("temp_led", bad ? WTM_LED_RED : WTM_LED_GREEN, temp_led);
      if (bad)
        chk("relay", 32'h0, relay);
    end
    rd_reg(WTM_REG_IRQ_STAT, d);
    chk("stat_temp", {31'h0, seen}, d[WTM_EV_TEMP]);
    chk("irq", {31'h0, seen}, irq);
    @(posedge clk_in);
    cpu_t <= clim[7:0];
    hsg_t <= hlim[15:8];
    cyc(8);
    wr_reg(WTM_REG_IRQ_CLR, 32'h3);
    cyc(1);
    chk("irq", 32'h0, irq);
    $display("test temperature done");
    // expiry with no reaction enabled, then no way back without a rearm
    wr_reg(WTM_REG_TIME, 32'h10);
    wr_reg(WTM_REG_CTRL, 32'h1);
    cyc(HOLD);
    wr_reg(WTM_REG_CTRL, 32'h11);
    chk("relay", 32'h1, relay);
    n = 0;
    while (run_led !== WTM_LED_RED && n < 80)
    begin
      cyc(1);
      n++;
    end
    if (n == 80)
    begin
      failures++;
      report_and_stop();
    end
    cyc(1);
    chk("relay", 32'h0, relay);
    chk("sys_rst", 32'h0, sys_rst);
    chk("irq", 32'h0, irq);
    cyc(HOLD);
    wr_reg(WTM_REG_CTRL, 32'h10);
    chk("relay", 32'h0, relay);
    $display("test quiet expiry done");
    // a cold restart in mid-run leaves everything quiet again
    @(posedge clk_in);
    reset_n_in <= 1'b0;
    cyc(2);
    chk("run_led", WTM_LED_OFF, run_led);
    chk("relay", 32'h0, relay);
    @(posedge clk_in);
    reset_n_in <= 1'b1;
    cyc(2);
    chk("run_led", WTM_LED_OFF, run_led);
    chk("temp_led", WTM_LED_GREEN, temp_led);
    chk("sys_rst", 32'h0, sys_rst);
    $display("test restart done");
    report_and_stop();
  end
endmodule

// File: wtm_alarm_model.sv
/*
  alarm unit on the relay changeover contact: times each fail stretch.
  assumes the relay drive is registered on clk_in.
*/
`timescale 1ns/1ns
module wtm_alarm_model
(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic relay_work_in,
  output logic [31:0] low_len_out
);
  logic [31:0] run_q; // cycles of the current fail stretch
  // fail contact closed while the coil is dropped; length kept on recovery
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      run_q <= 32'h0;
      low_len_out <= 32'h0;
    end
    else if (!relay_work_in)
      run_q <= run_q + 32'h1;
    else if (run_q != 32'h0)
    begin
      low_len_out <= run_q; // an alarm unit needs the whole stretch
      run_q <= 32'h0;
    end
  end
endmodule

// File: wtm_monitor.sv
/*
  watchdog, dual temperature supervision and fail-safe alarm relay.
  assumes temperature readings arrive as 8-bit codes from another clock
  domain, and that software uses the plain strobe register port.
*/
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/1ns
module wtm_monitor
  import wtm_pkg::*;
#(
  parameter int STEP_CYC = WTM_STEP_CYC,   // cycles per monitoring step
  parameter int HOLD_CYC = WTM_HOLD_CYC    // cycles of fail hold
)(
  input wire logic clk_in,
  input wire logic reset_n_in,
  input wire logic [3:0] addr_in,
  input wire logic [31:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  input wire logic [7:0] cpu_temp_in,
  input wire logic [7:0] hsg_temp_in,
  output logic [31:0] rdata_out,
  output logic relay_work_out,
  output logic [1:0] run_led_out,
  output logic [1:0] temp_led_out,
  output logic sys_reset_out,
  output logic irq_out
);

  // ----------------------------------------
  // temperature input synchronisers
  // ----------------------------------------
  // three stages; a reading counts once stages two and three agree
  logic [7:0] cpu_s1_q, cpu_s2_q, cpu_s3_q, cpu_ok_q;
  logic [7:0] hsg_s1_q, hsg_s2_q, hsg_s3_q, hsg_ok_q;

  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      // stages start at an in-window reading, so release does not flash a
      // false temperature error while the first real sample walks through
      cpu_s1_q <= WTM_LIM_LO_RST + 8'h01;
      cpu_s2_q <= WTM_LIM_LO_RST + 8'h01;
      cpu_s3_q <= WTM_LIM_LO_RST + 8'h01;
      cpu_ok_q <= WTM_LIM_LO_RST + 8'h01;
      hsg_s1_q <= WTM_LIM_LO_RST + 8'h01;
      hsg_s2_q <= WTM_LIM_LO_RST + 8'h01;
      hsg_s3_q <= WTM_LIM_LO_RST + 8'h01;
      hsg_ok_q <= WTM_LIM_LO_RST + 8'h01;
    end
    else
    begin
      cpu_s1_q <= cpu_temp_in;
      cpu_s2_q <= cpu_s1_q;
      cpu_s3_q <= cpu_s2_q;
      hsg_s1_q <= hsg_temp_in;
      hsg_s2_q <= hsg_s1_q;
      hsg_s3_q <= hsg_s2_q;
      // multi-bit codes may skew; only a settled value is taken
      if (cpu_s2_q == cpu_s3_q)
        cpu_ok_q <= cpu_s3_q;
      if (hsg_s2_q == hsg_s3_q)
        hsg_ok_q <= hsg_s3_q;
    end
  end

  // out-of-window test, used for both sensors
  function automatic logic wtm_out_of_lim(input logic [7:0] t, input wtm_lim_t lim);
    return (t > lim.hi) || (t < lim.lo);
  endfunction

  // ----------------------------------------
  // state update
  // ----------------------------------------
  wtm_state_t s_q, s_d;
  wtm_bus_t bus;
  logic wr_ctrl, wr_time, wr_kick, temp_bad, expire, retrig;
  logic [1:0] ev;

  assign bus = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};

  // one combinational pass over the whole state
  always_comb
  begin
    s_d = s_q;
    wr_ctrl = bus.wr && (bus.addr == WTM_REG_CTRL);
    wr_time = bus.wr && (bus.addr == WTM_REG_TIME);
    wr_kick = bus.wr && (bus.addr == WTM_REG_KICK);
    temp_bad = wtm_out_of_lim(cpu_ok_q, s_q.cpu_lim) || wtm_out_of_lim(hsg_ok_q, s_q.hsg_lim);
    expire = 1'b0;
    retrig = 1'b0;
    ev = 2'b00;

    // configuration writes
    if (wr_ctrl)
    begin
      s_d.rst_en = bus.wdata[WTM_CTRL_RST_EN];
      s_d.irq_en = bus.wdata[WTM_CTRL_IRQ_EN];
      s_d.tirq_en = bus.wdata[WTM_CTRL_TIRQ_EN];
    end
    if (bus.wr && bus.addr == WTM_REG_CPU_LIM)
      s_d.cpu_lim = bus.wdata[15:0];
    if (bus.wr && bus.addr == WTM_REG_HSG_LIM)
      s_d.hsg_lim = bus.wdata[15:0];
    if (bus.wr && bus.addr == WTM_REG_IRQ_EN)
      s_d.irq_en_mask = bus.wdata[1:0];
    if (wr_time)
      // values below the least count are raised to it
      s_d.wd_time = (bus.wdata[7:0] < WTM_TIME_MIN) ? WTM_TIME_MIN : bus.wdata[7:0];

    // watchdog arming: the relay drops while freshly armed until acknowledged
    if (wr_ctrl && bus.wdata[WTM_CTRL_ARM] && !s_q.armed)
    begin
      s_d.armed = 1'b1;
      s_d.fired = 1'b0;
      s_d.run_led = WTM_LED_GREEN;
      s_d.relay_work = 1'b0;
      retrig = 1'b1;
    end
    else if (wr_ctrl && !bus.wdata[WTM_CTRL_ARM] && s_q.armed)
    begin
      s_d.armed = 1'b0;
      s_d.run_led = WTM_LED_OFF;
    end

    // retrigger by kick or by a time change while armed
    if (s_q.armed && (wr_kick || wr_time))
      retrig = 1'b1;

    // step counting
    if (retrig)
    begin
      s_d.pre_cnt = 32'h0;
      s_d.step_left = wr_time ? s_d.wd_time : s_q.wd_time;
    end
    else if (s_q.armed)
    begin
      if (s_q.pre_cnt >= 32'(STEP_CYC - 1))
      begin
        s_d.pre_cnt = 32'h0;
        if (s_q.step_left <= 8'h01)
          expire = 1'b1;
        else
          s_d.step_left = s_q.step_left - 8'h01;
      end
      else
        s_d.pre_cnt = s_q.pre_cnt + 32'h1;
    end

    // expiry reactions
    if (expire)
    begin
      s_d.armed = 1'b0;
      s_d.fired = 1'b1;
      s_d.run_led = WTM_LED_RED;
      s_d.relay_work = 1'b0;
      s_d.hold_cnt = 32'(HOLD_CYC);
      ev[WTM_EV_EXPIRE] = s_q.irq_en;
      if (s_q.rst_en)
        s_d.sys_rst_cnt = 5'(WTM_RST_PULSE_CYC);
    end

    // temperature supervision
    s_d.temp_err = temp_bad;
    s_d.temp_led = temp_bad ? WTM_LED_RED : WTM_LED_GREEN;
    if (temp_bad)
    begin
      s_d.relay_work = 1'b0;
      s_d.hold_cnt = 32'(HOLD_CYC);
      ev[WTM_EV_TEMP] = s_q.tirq_en && !s_q.temp_err;
    end

    // hold timer; acknowledge only acts once the fail state is gone
    if (!temp_bad && !expire && s_q.hold_cnt != 32'h0)
      s_d.hold_cnt = s_q.hold_cnt - 32'h1;
    if (wr_ctrl && bus.wdata[WTM_CTRL_ACK] && !temp_bad && !expire && s_q.hold_cnt == 32'h0
        && !(s_q.fired && !s_q.armed))
      s_d.relay_work = 1'b1;
    if (wr_ctrl && bus.wdata[WTM_CTRL_ARM] && !s_q.armed)
      s_d.fired = 1'b0;

    // system reset pulse
    s_d.sys_rst = s_q.sys_rst_cnt != 5'h0;
    if (!expire && s_q.sys_rst_cnt != 5'h0)
      s_d.sys_rst_cnt = s_q.sys_rst_cnt - 5'h1;

    // sticky interrupt status: set wins over clear
    if (bus.wr && bus.addr == WTM_REG_IRQ_CLR)
      s_d.irq_stat = s_q.irq_stat & ~bus.wdata[1:0];
    s_d.irq_stat = s_d.irq_stat | ev;
    s_d.irq = |(s_d.irq_stat & s_d.irq_en_mask);

    // read data, valid the cycle after the strobe only
    s_d.rdata = 32'h0;
    if (bus.rd)
    begin
      case (bus.addr)
        WTM_REG_CTRL: s_d.rdata = {27'h0, 1'b0, s_q.tirq_en, s_q.irq_en, s_q.rst_en, s_q.armed};
        WTM_REG_TIME: s_d.rdata = {24'h0, s_q.wd_time};
        WTM_REG_CPU_LIM: s_d.rdata = {16'h0, s_q.cpu_lim};
        WTM_REG_HSG_LIM: s_d.rdata = {16'h0, s_q.hsg_lim};
        WTM_REG_STATUS: s_d.rdata = {12'h0, s_q.step_left, 4'h0, s_q.run_led, s_q.temp_led,
                                     s_q.relay_work, s_q.temp_err, s_q.fired, s_q.armed};
        WTM_REG_IRQ_STAT: s_d.rdata = {30'h0, s_q.irq_stat};
        WTM_REG_IRQ_EN: s_d.rdata = {30'h0, s_q.irq_en_mask};
        default: s_d.rdata = 32'h0;   // write-only and unmapped read zero
      endcase
    end
  end

  // register the whole state; relay de-energized and watchdog quiet on reset
  always_ff @(posedge clk_in or negedge reset_n_in)
  begin
    if (!reset_n_in)
    begin
      s_q <= '0;
      s_q.wd_time <= WTM_TIME_RST;
      s_q.cpu_lim <= '{hi: WTM_LIM_HI_RST, lo: WTM_LIM_LO_RST};
      s_q.hsg_lim <= '{hi: WTM_LIM_HI_RST, lo: WTM_LIM_LO_RST};
    end
    else
      s_q <= s_d;
  end

  assign rdata_out = s_q.rdata;
  assign relay_work_out = s_q.relay_work;
  assign run_led_out = s_q.run_led;
  assign temp_led_out = s_q.temp_led;
  assign sys_reset_out = s_q.sys_rst;
  assign irq_out = s_q.irq;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  sequence wd_expire_seq;
    s_q.armed && !retrig && expire;
  endsequence

  // a fresh arm without acknowledge in the same write
  sequence wd_arm_seq;
    wr_ctrl && bus.wdata[WTM_CTRL_ARM] && !bus.wdata[WTM_CTRL_ACK] && !s_q.armed;
  endsequence

  // an acknowledge that no fail condition may refuse
  sequence wd_ack_ok_seq;
    wr_ctrl && bus.wdata[WTM_CTRL_ACK] && !temp_bad && !expire
      && s_q.hold_cnt == 32'h0 && !s_q.fired;
  endsequence

  a_quiet_after_reset: assert property (@(posedge clk_in) $rose(reset_n_in) |-> s_q.run_led == WTM_LED_OFF)
    else $error("run light not dark after reset");
  a_armed_green: assert property (@(posedge clk_in) disable iff (!reset_n_in) s_q.armed |-> s_q.run_led == WTM_LED_GREEN)
    else $error("armed watchdog without green light");
  a_expiry_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_expire_seq |=> !s_q.armed && s_q.run_led == WTM_LED_RED && !s_q.relay_work)
    else $error("expiry did not disarm and drop relay");
  a_expiry_irq: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_expire_seq ##0 !s_q.irq_stat[WTM_EV_EXPIRE] |=> s_q.irq_stat[WTM_EV_EXPIRE] == $past(s_q.irq_en))
    else $error("expiry interrupt does not follow its enable");
  a_expiry_reset: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_expire_seq ##0 s_q.rst_en |=> ##1 s_q.sys_rst)
    else $error("expiry reset not raised");
  a_time_min: assert property (@(posedge clk_in) disable iff (!reset_n_in) s_q.wd_time >= WTM_TIME_MIN)
    else $error("monitoring time below three");
  a_hold_relay: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.hold_cnt != 32'h0 |-> !s_q.relay_work)
    else $error("relay released during hold");
  a_temp_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      temp_bad |=> !s_q.relay_work && s_q.temp_led == WTM_LED_RED)
    else $error("temperature error did not drop relay");
  a_retrig_time: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.armed && wr_time && !expire |=> s_q.pre_cnt == 32'h0)
    else $error("time write did not retrigger");

  // arming, acknowledge, the fail lock, reset pulse, temperature, prescaler, kick, clear and hold
  // a fresh arm lights green and drops the relay until acknowledged
  a_arm_drop: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_arm_seq |=> s_q.armed && !s_q.relay_work && s_q.run_led == WTM_LED_GREEN)
    else $error("arming did not drop relay");
  // an acknowledge outside any fail state energizes the relay
  a_ack_work: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_ack_ok_seq |=> s_q.relay_work)
    else $error("acknowledge did not energize relay");
  // after expiry only a new arm may lift the relay
  a_fail_locked: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.fired && !s_q.armed && !s_q.relay_work |=> !s_q.relay_work)
    else $error("relay lifted out of fail state");
  // the red run light stays until the watchdog is armed again
  a_red_held: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.fired && !s_q.armed |-> s_q.run_led == WTM_LED_RED)
    else $error("run light not red after expiry");
  // a disabled reset reaction leaves the pulse counter idle
  a_rst_disabled: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_expire_seq ##0 !s_q.rst_en && s_q.sys_rst_cnt == 5'h0 |=> s_q.sys_rst_cnt == 5'h0)
    else $error("reset pulse without enable");
  // a fresh temperature error records its event when enabled
  a_temp_event: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      temp_bad && !s_q.temp_err && s_q.tirq_en |=> s_q.irq_stat[WTM_EV_TEMP])
    else $error("temperature event not recorded");
  // readings inside both windows turn the light green
  a_temp_green: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      !temp_bad |=> s_q.temp_led == WTM_LED_GREEN && !s_q.temp_err)
    else $error("temperature light not green");
  // the prescaler never runs past one step
  a_step_bound: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.pre_cnt < 32'(STEP_CYC))
    else $error("step prescaler overran");
  // a kick reloads the full monitoring time
  a_kick_retrig: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      s_q.armed && wr_kick |=> s_q.pre_cnt == 32'h0 && s_q.step_left == $past(s_q.wd_time))
    else $error("kick did not reload the count");
  // a clear with no new expiry empties the sticky bit
  a_clear_ok: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      bus.wr && bus.addr == WTM_REG_IRQ_CLR && bus.wdata[WTM_EV_EXPIRE] && !expire |=> !s_q.irq_stat[WTM_EV_EXPIRE])
    else $error("expiry event not cleared");
  // every expiry starts a full error hold
  a_hold_load: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wd_expire_seq |=> s_q.hold_cnt == 32'(HOLD_CYC))
    else $error("expiry did not load the hold");
  // disarming by software darkens the run light
  a_disarm_dark: assert property (@(posedge clk_in) disable iff (!reset_n_in)
      wr_ctrl && !bus.wdata[WTM_CTRL_ARM] && s_q.armed && !expire |=> !s_q.armed && s_q.run_led == WTM_LED_OFF)
    else $error("disarm left the run light on");

endmodule

// File: wtm_pkg.sv
/*
  package of the watchdog, temperature and relay monitor: register offsets,
  field positions, reset values, timing constants and carrier types.
  assumes a single 100 MHz clock domain and a plain strobe register port.
*/
package wtm_pkg;

  // ----------------------------------------
  // register map (word index on the plain port)
  // ----------------------------------------
  localparam logic [3:0] WTM_REG_CTRL = 4'h0;       // control: arm, enables, ack
  localparam logic [3:0] WTM_REG_TIME = 4'h1;       // watchdog_monitoring_time steps
  localparam logic [3:0] WTM_REG_KICK = 4'h2;       // any write retriggers
  localparam logic [3:0] WTM_REG_CPU_LIM = 4'h3;    // processor limits hi:lo
  localparam logic [3:0] WTM_REG_HSG_LIM = 4'h4;    // housing limits hi:lo
  localparam logic [3:0] WTM_REG_STATUS = 4'h5;     // live state, read only
  localparam logic [3:0] WTM_REG_IRQ_STAT = 4'h6;   // sticky events, read only
  localparam logic [3:0] WTM_REG_IRQ_CLR = 4'h7;    // write one to clear
  localparam logic [3:0] WTM_REG_IRQ_EN = 4'h8;     // interrupt enables

  // ----------------------------------------
  // control field positions
  // ----------------------------------------
  localparam int WTM_CTRL_ARM = 0;       // arm the watchdog_unit
  localparam int WTM_CTRL_RST_EN = 1;    // expiry drives system reset
  localparam int WTM_CTRL_IRQ_EN = 2;    // expiry raises interrupt
  localparam int WTM_CTRL_TIRQ_EN = 3;   // temperature error raises interrupt
  localparam int WTM_CTRL_ACK = 4;       // acknowledge: relay to working

  // ----------------------------------------
  // event bits of the interrupt registers
  // ----------------------------------------
  localparam int WTM_EV_EXPIRE = 0;
  localparam int WTM_EV_TEMP = 1;

  // ----------------------------------------
  // reset values and timing
  // ----------------------------------------
  localparam logic [7:0] WTM_TIME_MIN = 8'h03;      // least legal step count
  localparam logic [7:0] WTM_TIME_RST = 8'hff;      // step count after reset
  localparam logic [7:0] WTM_LIM_HI_RST = 8'h50;    // upper limit after reset
  localparam logic [7:0] WTM_LIM_LO_RST = 8'h05;    // lower limit after reset
  localparam int WTM_CLK_MHZ = 100;                 // clock rate
  localparam int WTM_HOLD_MS = 500;                 // least error hold time
  localparam int WTM_HOLD_CYC = WTM_HOLD_MS * 1000 * WTM_CLK_MHZ;
  localparam int WTM_STEP_US = 100000;              // one monitoring step
  localparam int WTM_STEP_CYC = WTM_STEP_US * WTM_CLK_MHZ;
  localparam int WTM_RST_PULSE_CYC = 16;            // length of system reset pulse

  // ----------------------------------------
  // carrier types
  // ----------------------------------------
  typedef enum logic [1:0] {
    WTM_LED_OFF = 2'b00,
    WTM_LED_GREEN = 2'b01,
    WTM_LED_RED = 2'b10
  } wtm_led_t;

  typedef struct packed {
    logic [7:0] hi;   // upper limit
    logic [7:0] lo;   // lower limit
  } wtm_lim_t;

  typedef struct packed {
    logic [3:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } wtm_bus_t;

  typedef struct packed {
    logic armed;            // watchdog_unit running
    logic fired;            // expiry seen since last arm
    logic rst_en;
    logic irq_en;
    logic tirq_en;
    logic [7:0] wd_time;    // watchdog_monitoring_time
    logic [7:0] step_left;  // steps remaining
    logic [31:0] pre_cnt;   // step prescaler
    logic [31:0] hold_cnt;  // fail hold counter
    logic relay_work;       // 1 = energized working position
    logic temp_err;
    wtm_lim_t cpu_lim;
    wtm_lim_t hsg_lim;
    logic [1:0] irq_stat;
    logic [1:0] irq_en_mask;
    logic [4:0] sys_rst_cnt;
    logic sys_rst;
    logic irq;
    logic [31:0] rdata;
    wtm_led_t run_led;
    wtm_led_t temp_led;
  } wtm_state_t;

endpackage
